//--- core/dsf_fifo.sv
// Synchronous word buffer with valid/ready on both sides.
// Assumes both sides run on the same clock as the writer.
`timescale 1ns/1ps
module dsf_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  // Filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  wire          push = in_valid & in_ready;
  wire          pop  = out_valid & out_ready;
  wire          full = (wr_ptr[AW] != rd_ptr[AW]) &&
                       (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);

  assign in_ready  = ~full;
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  chk_no_overfill: assert property (@(posedge sys_clk) disable iff (!rstn)
    full |=> !(wr_ptr == rd_ptr)) else $error("Buffer lost its contents.");

endmodule

//--- core/dsf_frame_input.sv
// Serial write port of an eight channel converter: shift, commit, chain.
// Assumes serial pins are asynchronous and far slower than sys_clk.
`timescale 1ns/1ps

// Notes on behaviour
// - Shift one bit per falling clock edge.
// - Rise after sixteen edges commits the word.
// - Rise before sixteenth edge aborts the write.
// - Chain output only after sixteen held clocks.
// - Chain output feeds next device's input.
// - Committed word sets mode, power-down, values.
// - Outputs stay zero until first valid word.
// - Update all channels together or singly.
module dsf_frame_input
  import dsf_pkg::*;
(
  // Clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         rstn,
  // Serial pins
  input  wire logic                         sclk,
  input  wire logic                         sync_n,
  input  wire logic                         din,
  output logic                              dout,
  // Converter core side
  input  wire logic                         apply_en,
  output logic [CHAN_N-1:0][CODE_W-1:0]     chan_code,
  output logic [CODE_W-1:0]                 channel_one_output,
  output logic [CHAN_N-1:0]                 pd_mask,
  output logic [1:0]                        pd_mode,
  // Status
  output logic                              accept_ready,
  output logic                              overrun
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic             sclk_m, sclk_s, sclk_d;
  logic             sync_m, sync_s, sync_d;
  logic             din_m, din_s;

  // All three pins share the same latency, so data stays aligned to clock.
  // The serial clock idles high, so its stages reset high to match.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      {sclk_m, sclk_s, sclk_d} <= 3'h7;
      {sync_m, sync_s, sync_d} <= 3'h7;
      {din_m, din_s}           <= 2'h0;
    end else begin
      {sclk_m, sclk_s, sclk_d} <= {sclk, sclk_m, sclk_s};
      {sync_m, sync_s, sync_d} <= {sync_n, sync_m, sync_s};
      {din_m, din_s}           <= {din, din_m};
    end
  end

  wire              sclk_fall = sclk_d & ~sclk_s;
  wire              in_frame  = ~sync_s;
  wire              sync_rise = ~sync_d & sync_s;

  // ----------------------------------------------------------------------
  // Shift register and edge count
  // ----------------------------------------------------------------------
  logic [WORD_W-1:0] shreg;
  logic [CNT_W-1:0]  edge_cnt;
  logic              push_ok;
  wire               shift_en  = in_frame & sclk_fall;
  wire               long_frm  = (edge_cnt >= FULL_EDGES);
  wire               commit    = sync_rise & long_frm;
  wire [CNT_W-1:0]   next_cnt  = (edge_cnt == CNT_MAX) ? edge_cnt :
                                 edge_cnt + 1'b1;
  wire               next_dout = in_frame & long_frm & shreg[WORD_W-1];

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      shreg <= '0;
    end else if (shift_en) begin
      shreg <= {shreg[WORD_W-2:0], din_s};
    end
  end

  // The count saturates so long chained frames still read as complete.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      edge_cnt <= '0;
    end else if (!in_frame) begin
      edge_cnt <= '0;
    end else if (sclk_fall) begin
      edge_cnt <= next_cnt;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dout <= 1'b0;
    end else begin
      dout <= next_dout;
    end
  end

  // ----------------------------------------------------------------------
  // Commit into the word buffer
  // ----------------------------------------------------------------------
  logic [WORD_W-1:0] word;
  logic              word_valid;
  wire               word_pop = word_valid & apply_en;

  dsf_fifo #(
    .W     (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_buf (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .in_valid  (commit),
    .in_ready  (push_ok),
    .in_data   (shreg),
    .out_valid (word_valid),
    .out_ready (apply_en),
    .out_data  (word)
  );

  assign accept_ready = push_ok;

  // A full buffer cannot stall the host, so the word is dropped and flagged.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      overrun <= 1'b0;
    end else begin
      overrun <= commit & ~push_ok;
    end
  end

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  logic [CHAN_N-1:0][CODE_W-1:0] hold;
  wire               is_cmd   = word[CMD_BIT];
  wire [CH_W-1:0]    ch_sel   = word[CH_LSB +: CH_W];
  wire [CODE_W-1:0]  new_code = word[CODE_LSB +: CODE_W];
  wire [1:0]         op       = word[OP_LSB +: 2];
  wire               wr_ch    = word_pop & ~is_cmd;
  wire               ld_now   = wr_ch & word[LOAD_BIT];
  wire               upd_all  = word_pop & is_cmd & (op == OP_UPD_ALL);
  wire               pwr_set  = word_pop & is_cmd & (op == OP_POWER);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hold <= '0;
    end else if (wr_ch) begin
      hold[ch_sel] <= new_code;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      chan_code <= {CHAN_N{CODE_RST}};
    end else if (upd_all) begin
      chan_code <= hold;
    end else if (ld_now) begin
      chan_code[ch_sel] <= new_code;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pd_mask <= PD_MASK_RST;
      pd_mode <= PD_MODE_RST;
    end else if (pwr_set) begin
      pd_mask <= word[PD_MASK_LSB +: CHAN_N];
      pd_mode <= word[PD_MODE_LSB +: 2];
    end
  end

  assign channel_one_output = chan_code[0];

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic written;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      written <= 1'b0;
    end else if (word_pop) begin
      written <= 1'b1;
    end
  end

  sequence s_full_rise;
    sync_rise && (edge_cnt >= FULL_EDGES);
  endsequence
  sequence s_mid_rise;
    sync_rise && (edge_cnt == ABORT_EDGE);
  endsequence

  chk_shift_bit: assert property (@(posedge sys_clk) disable iff (!rstn)
    shift_en |=> shreg == {$past(shreg[WORD_W-2:0]), $past(din_s)})
    else $error("Shift register missed a bit.");
  chk_commit_word: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_full_rise ##0 push_ok |-> u_buf.push)
    else $error("Complete frame was not committed.");
  chk_abort_early: assert property (@(posedge sys_clk) disable iff (!rstn)
    sync_rise && (edge_cnt < ABORT_EDGE) |-> !commit)
    else $error("Short frame was committed.");
  chk_abort_mid: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_mid_rise |-> !commit ##1 !word_valid || $stable(u_buf.wr_ptr))
    else $error("Fifteen edge frame was committed.");
  chk_dout_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
    !long_frm |=> !dout)
    else $error("Chain output active too early.");
  chk_dout_chain: assert property (@(posedge sys_clk) disable iff (!rstn)
    in_frame && long_frm |=> dout == $past(shreg[WORD_W-1]))
    else $error("Chain output does not follow the oldest bit.");
  chk_zero_start: assert property (@(posedge sys_clk) disable iff (!rstn)
    !written |-> chan_code == '0)
    else $error("Output moved before any valid word.");
  chk_update_all: assert property (@(posedge sys_clk) disable iff (!rstn)
    upd_all |=> chan_code == $past(hold))
    else $error("Simultaneous update missed a channel.");
  chk_chan_load: assert property (@(posedge sys_clk) disable iff (!rstn)
    ld_now && !upd_all |=> chan_code[$past(ch_sel)] == $past(new_code))
    else $error("Single channel load failed.");

endmodule

//--- core/dsf_pkg.sv
// Constants shared by the serial frame input port and its word buffer.
// Assumes one system clock; all serial pins arrive asynchronously.
package dsf_pkg;

  // ----------------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------------
  localparam int         WORD_W      = 16;
  localparam int         CHAN_N      = 8;
  localparam int         CODE_W      = 10;
  localparam int         FIFO_DEPTH  = 16;
  localparam int         CNT_W       = 5;
  localparam logic [4:0] FULL_EDGES  = 5'h10;
  localparam logic [4:0] ABORT_EDGE  = 5'h0f;
  localparam logic [4:0] CNT_MAX     = 5'h1f;

  // ----------------------------------------------------------------------
  // Command word layout
  // ----------------------------------------------------------------------
  localparam int         CMD_BIT     = 15;
  localparam int         CH_LSB      = 12;
  localparam int         CH_W        = 3;
  localparam int         CODE_LSB    = 2;
  localparam int         LOAD_BIT    = 0;
  localparam int         OP_LSB      = 13;
  localparam logic [1:0] OP_UPD_ALL  = 2'h0;
  localparam logic [1:0] OP_POWER    = 2'h1;
  localparam int         PD_MASK_LSB = 0;
  localparam int         PD_MODE_LSB = 8;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [9:0] CODE_RST    = 10'h000;
  localparam logic [7:0] PD_MASK_RST = 8'h00;
  localparam logic [1:0] PD_MODE_RST = 2'h0;

endpackage

//--- verif/dsf_frame_input_tb.sv
// Bench for the serial frame input port with a host model.
// Assumes the package constants and the chosen word layout.
`timescale 1ns/1ps
module dsf_frame_input_tb
  import dsf_pkg::*;
;
  typedef logic [89:0] dsf_note_t;
  logic                          sys_clk, rstn, apply_en;
  logic                          sclk, sync_n, din, dout;
  logic [CHAN_N-1:0][CODE_W-1:0] chan_code, hold, code_e;
  logic [CODE_W-1:0]             ch1;
  logic [CHAN_N-1:0]             pd_mask, mask_e;
  logic [1:0]                    pd_mode, mode_e;
  logic                          accept_ready, overrun;
  logic [31:0]                   cap;
  logic [15:0]                   rnd;
  dsf_note_t                     notes[$];
  dsf_note_t                     last_e, prev, seen, exp_n;
  int                            n_mismatch, num_checks, n_ovr;

  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;

  dsf_frame_input u_dut (.sys_clk(sys_clk), .rstn(rstn), .sclk(sclk),
    .sync_n(sync_n), .din(din), .dout(dout), .apply_en(apply_en),
    .chan_code(chan_code), .channel_one_output(ch1), .pd_mask(pd_mask),
    .pd_mode(pd_mode), .accept_ready(accept_ready), .overrun(overrun));
  dsf_host u_host (.sys_clk(sys_clk), .sclk(sclk), .sync_n(sync_n),
    .din(din), .dout(dout), .cap(cap));

  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  function automatic logic [15:0] mk(input logic [2:0] c,
                                     input logic [9:0] v, input logic l);
    return {1'b0, c, v, 1'b0, l};
  endfunction

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic model(input logic [15:0] w);
    if (!w[15]) begin
      hold[w[14:12]] = w[11:2];
      if (w[0]) code_e[w[14:12]] = w[11:2];
    end else if (w[14:13] == OP_UPD_ALL) begin
      code_e = hold;
    end else if (w[14:13] == OP_POWER) begin
      mask_e = w[7:0];
      mode_e = w[9:8];
    end
    if ({code_e, mask_e, mode_e} != last_e) begin
      last_e = {code_e, mask_e, mode_e};
      notes.push_back(last_e);
    end
  endtask

  // Short frames are aborts, so only full ones are noted.
  task automatic wr(input logic [31:0] w, input int n);
    if (n >= 16) model(w[15:0]);
    u_host.send(w, n);
  endtask

  always @(negedge sys_clk) begin
    if (rstn) begin
      if (overrun === 1'b1) n_ovr++;
      seen = {chan_code, pd_mask, pd_mode};
      if (seen !== prev) begin
        if (notes.size() == 0) check(1'b0, "unexpected update");
        else begin
          exp_n = notes.pop_front();
          check(seen === exp_n, "wrong update");
          check(ch1 === exp_n[19:10], "channel one copy");
        end
      end
      prev = seen;
    end
  end

  initial begin
    #400us;
    n_mismatch++;
    $display("Error at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    {rstn, hold, code_e, mask_e, mode_e, last_e, prev} = '0;
    apply_en   = 1'b1;
    rnd        = 16'hfab1;
    n_mismatch = 0;
    num_checks = 0;
    n_ovr      = 0;
    repeat (8) @(negedge sys_clk);
    check({chan_code, pd_mask, pd_mode, dout} === '0, "reset");
    rstn = 1'b1;
    wr(mk(3'h0, 10'h155, 1'b1), 16);
    wr(mk(3'h7, 10'h2aa, 1'b0), 16);
    wr(16'h8000, 16);
    wr({3'h5, 3'h0, 2'h2, 8'ha5}, 16);
    wr(16'hc0ff, 16);
    wr(16'he0ff, 16);
    wr(mk(3'h1, 10'h3ff, 1'b1), 5);
    wr(mk(3'h1, 10'h3ff, 1'b1), 15);
    wr({16'hc3a5, mk(3'h3, 10'h0f0, 1'b1)}, 32);
    check(cap === 32'h0000c3a5, "chain output");
    // Random writes through the LFSR.
    for (int i = 0; i < 10; i++) begin
      rnd = lfsr(rnd);
      wr(rnd, 16);
    end
    // Stall the core so the buffer fills, then overflow it once.
    // The last random word must drain first, or it takes a buffer slot.
    repeat (8) @(negedge sys_clk);
    apply_en = 1'b0;
    for (int i = 0; i < 16; i++)
      wr(mk(3'(i), 10'h100 + 10'(i), 1'b1), 16);
    repeat (8) @(negedge sys_clk);
    check(accept_ready === 1'b0, "buffer full");
    u_host.send(mk(3'h2, 10'h3c3, 1'b1), 16);
    repeat (8) @(negedge sys_clk);
    check(n_ovr == 1, "overrun pulse");
    apply_en = 1'b1;
    repeat (40) @(negedge sys_clk);
    check(notes.size() == 0, "updates missing");
    check(accept_ready === 1'b1, "buffer drained");
    end_of_test();
  end
endmodule

//--- verif/dsf_host.sv
// Host serial controller model for the frame input port.
// Assumes the bench clock; pins move on its falling edge.
`timescale 1ns/1ps
module dsf_host (
  // Clock
  input  wire logic        sys_clk,
  // Serial pins
  output logic             sclk,
  output logic             sync_n,
  output logic             din,
  input  wire logic        dout,
  // Chain capture
  output logic [31:0]      cap
);
  initial begin
    sclk   = 1'b1;
    sync_n = 1'b1;
    din    = 1'b0;
    cap    = 32'h0;
  end
  task automatic send(input logic [31:0] w, input int n);
    repeat (4) @(negedge sys_clk);
    sync_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      din = w[i];
      repeat (4) @(negedge sys_clk);
      cap  = {cap[30:0], dout};
      sclk = 1'b0;
      repeat (4) @(negedge sys_clk);
      sclk = 1'b1;
    end
    repeat (4) @(negedge sys_clk);
    sync_n = 1'b1;
    // Released data line must not keep its last level.
    din = ~din;
  endtask
endmodule
